// ===== hdl/sfpp_pkg.sv
package sfpp_pkg;

  // ********************************************************
  // Clock and frame bit positions
  // ********************************************************
  localparam int unsigned CLOCK_MHZ = 125;
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] OPCODE_END = 16'h0008;
  localparam logic [15:0] STATUS_DATA_END = 16'h0010;
  localparam logic [15:0] ADDR_END = 16'h0020;
  localparam logic [15:0] DUMMY_END = 16'h0028;

  // ********************************************************
  // Command codes
  // ********************************************************
  localparam logic [7:0] CMD_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] CMD_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_DUAL_READ = 8'h3B;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_FOUR_KIB_WIPE = 8'h20;
  localparam logic [7:0] CMD_BLOCK32_WIPE = 8'h52;
  localparam logic [7:0] CMD_BLOCK64_WIPE = 8'hD8;
  localparam logic [7:0] CMD_ARRAY_WIPE_A = 8'h60;
  localparam logic [7:0] CMD_ARRAY_WIPE_B = 8'hC7;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hB9;
  localparam logic [7:0] CMD_WAKE = 8'hAB;

  // ********************************************************
  // Array geometry and protection limits (exclusive ends)
  // ********************************************************
  localparam int unsigned DENSITY_1M_KBIT = 1024;
  localparam int unsigned DENSITY_512K_KBIT = 512;
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned SECTOR_BYTES = 4096;
  localparam int unsigned BLOCK32_BYTES = 32768;
  localparam int unsigned BLOCK64_BYTES = 65536;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [23:0] LIM_NONE = 24'h000000;
  localparam logic [23:0] LIM_1M_CODE1 = 24'h01E000;
  localparam logic [23:0] LIM_1M_CODE2 = 24'h01C000;
  localparam logic [23:0] LIM_1M_CODE3 = 24'h018000;
  localparam logic [23:0] LIM_1M_CODE4 = 24'h010000;
  localparam logic [23:0] LIM_1M_ALL = 24'h020000;
  localparam logic [23:0] LIM_512K_CODE1 = 24'h00E000;
  localparam logic [23:0] LIM_512K_CODE2 = 24'h00C000;
  localparam logic [23:0] LIM_512K_CODE3 = 24'h008000;
  localparam logic [23:0] LIM_512K_ALL = 24'h010000;

  // ********************************************************
  // Reset values and operation times
  // ********************************************************
  localparam logic [2:0] RESET_PROTECT = 3'h0;
  localparam logic RESET_LOCK = 1'h0;
  localparam logic RESET_LATCH = 1'h0;
  localparam int unsigned PAGE_PROGRAM_US = 700;
  localparam int unsigned FOUR_KIB_WIPE_US = 100000;
  localparam int unsigned BLOCK32_WIPE_US = 300000;
  localparam int unsigned BLOCK64_WIPE_US = 500000;
  localparam int unsigned ARRAY_WIPE_1M_US = 1000000;
  localparam int unsigned ARRAY_WIPE_512K_US = 500000;
  localparam int unsigned PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_US * CLOCK_MHZ;
  localparam int unsigned FOUR_KIB_WIPE_CYCLES = FOUR_KIB_WIPE_US * CLOCK_MHZ;
  localparam int unsigned BLOCK32_WIPE_CYCLES = BLOCK32_WIPE_US * CLOCK_MHZ;
  localparam int unsigned BLOCK64_WIPE_CYCLES = BLOCK64_WIPE_US * CLOCK_MHZ;
  localparam int unsigned ARRAY_WIPE_1M_CYCLES = ARRAY_WIPE_1M_US * CLOCK_MHZ;
  localparam int unsigned ARRAY_WIPE_512K_CYCLES = ARRAY_WIPE_512K_US * CLOCK_MHZ;
  localparam logic [31:0] STATUS_WRITE_CYCLES = 32'h00000010;

endpackage

// ===== hdl/sfpp_ram.sv
`timescale 1ns/100ps
module sfpp_ram #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  input wire logic wr_clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_clock,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge wr_clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port on its own clock
  always_ff @(posedge rd_clock) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// ===== hdl/sfpp_top.sv
// Function
// - Four wires: serial clock, low-active select, data in, data out.
// - Works with serial clock idling low or high (modes 0 and 3).
// - Sample input on rising clock edge, change output on falling edge.
// - Dual fast read returns data on two lanes, double bit rate.
// - Dual read drives both lanes; host releases the input lane.
// - Write enable command sets latch; needed for program, erase, status write.
// - Latch clears at reset, disable, and at each accepted status write, program or erase.
// - Range chosen by protect bits is read-only to program and erase.
// - Protect pin low with lock bit set guards protect bits and lock bit.
// - In deep power-down only the release command is obeyed.
// - 1-Mbit codes 000 none, 001/010/011 lower 120/112/96 KiB.
// - 1-Mbit code 100 lower 64 KiB; 101 to 111 whole array.
// - Program writes at most one aligned 256-byte page, wrapping inside it.
// - Sector erase clears an aligned 4 KiB sector.
// - Block erase clears an aligned 32 KiB or 64 KiB block.
// - Lock bit set with pin low: status writes not executed.
// - Whole-array erase only when all protect bits are zero.
// - Write-type commands need select raised on a byte boundary.
// - Busy flag is one during program, erase or status write.
`timescale 1ns/100ps
module sfpp_top #(
  parameter int unsigned DENSITY_KBIT = sfpp_pkg::DENSITY_1M_KBIT,
  parameter int unsigned PROGRAM_CYCLES = sfpp_pkg::PAGE_PROGRAM_CYCLES,
  parameter int unsigned SECTOR_CYCLES = sfpp_pkg::FOUR_KIB_WIPE_CYCLES,
  parameter int unsigned BLOCK32_CYCLES = sfpp_pkg::BLOCK32_WIPE_CYCLES,
  parameter int unsigned BLOCK64_CYCLES = sfpp_pkg::BLOCK64_WIPE_CYCLES,
  parameter int unsigned ARRAY_1M_CYCLES = sfpp_pkg::ARRAY_WIPE_1M_CYCLES,
  parameter int unsigned ARRAY_512K_CYCLES = sfpp_pkg::ARRAY_WIPE_512K_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic dual_lane_zero_in,
  output logic dual_lane_zero_out,
  output logic dual_lane_zero_oe_n,
  output logic dual_lane_one_out,
  output logic dual_lane_one_oe_n,
  input wire logic write_protect_n,
  output logic busy_flag,
  output logic write_enable_latch,
  output logic [2:0] protect_range_bits,
  output logic status_lock_bit,
  output logic deep_power_down
);

  localparam int AW = $clog2(DENSITY_KBIT * 128);
  localparam int unsigned ARRAY_BYTES = 1 << AW;
  localparam bit BIG = (DENSITY_KBIT == sfpp_pkg::DENSITY_1M_KBIT);

  // ********************************************************
  // Link side: frame capture on the serial clock
  // ********************************************************
  logic fresh;
  logic [15:0] cnt;
  logic [15:0] cnt_now;
  logic [31:0] shift;
  logic [7:0] opcode;
  logic [7:0] sr_data;
  logic [23:0] addr;
  logic [8:0] pp_count;
  logic [AW-1:0] cur_addr;
  logic [23:0] assembled;
  logic [15:0] data_start;
  logic [15:0] phase;
  logic in_data;
  logic dual;
  logic byte_start;
  logic awake;
  logic pb_we;
  logic [7:0] pb_waddr;
  logic [AW-1:0] arr_raddr;
  logic [7:0] arr_rdata;
  logic [8:0] st_s1;
  logic [8:0] st_s2;
  logic [7:0] out_byte;
  logic [7:0] sh;

  // Select high holds the frame start flag; cleared at the first rising edge
  always_ff @(posedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      fresh <= 1'h1;
    end else begin
      fresh <= 1'h0;
    end
  end

  assign cnt_now = fresh ? 16'h0000 : cnt;
  assign assembled = {shift[22:0], dual_lane_zero_in};

  // Bits are taken on rising edges only
  always_ff @(posedge serial_clock) begin
    cnt <= cnt_now + 16'h0001;
    shift <= {shift[30:0], dual_lane_zero_in};
  end

  always_ff @(posedge serial_clock) begin
    if (cnt_now == sfpp_pkg::OPCODE_END - 16'h0001) begin
      opcode <= assembled[7:0];
    end
    if (cnt_now == sfpp_pkg::STATUS_DATA_END - 16'h0001) begin
      sr_data <= assembled[7:0];
    end
    if (cnt_now == sfpp_pkg::ADDR_END - 16'h0001) begin
      addr <= assembled;
    end
  end

  always_comb begin
    case (opcode)
      sfpp_pkg::CMD_STATUS_READ: data_start = sfpp_pkg::OPCODE_END;
      sfpp_pkg::CMD_READ: data_start = sfpp_pkg::ADDR_END;
      sfpp_pkg::CMD_FAST_READ: data_start = sfpp_pkg::DUMMY_END;
      sfpp_pkg::CMD_DUAL_READ: data_start = sfpp_pkg::DUMMY_END;
      default: data_start = 16'hFFFF;
    endcase
  end

  assign dual = (opcode == sfpp_pkg::CMD_DUAL_READ);
  assign phase = cnt_now - data_start;
  assign in_data = (cnt_now >= sfpp_pkg::OPCODE_END) && (cnt_now >= data_start);
  assign byte_start = dual ? (phase[1:0] == 2'h0) : (phase[2:0] == 3'h0);
  assign awake = !st_s2[8] || (opcode == sfpp_pkg::CMD_WAKE);

  // Plain read needs its first byte one edge after the address ends
  assign arr_raddr = ((cnt_now == sfpp_pkg::ADDR_END - 16'h0001) &&
                      (opcode == sfpp_pkg::CMD_READ)) ? assembled[AW-1:0] : cur_addr;

  always_ff @(posedge serial_clock) begin
    if (cnt_now == sfpp_pkg::ADDR_END - 16'h0001) begin
      cur_addr <= assembled[AW-1:0];
    end else if (in_data && byte_start) begin
      cur_addr <= cur_addr + 1'h1;
    end
  end

  // Page data goes to the buffer, wrapping inside the page
  assign pb_we = (opcode == sfpp_pkg::CMD_PAGE_PROGRAM) &&
                 (cnt_now >= sfpp_pkg::DUMMY_END - 16'h0001) && (cnt_now[2:0] == 3'h7);
  assign pb_waddr = addr[7:0] + pp_count[7:0];

  always_ff @(posedge serial_clock) begin
    if (fresh) begin
      pp_count <= 9'h000;
    end else if (pb_we && !pp_count[8]) begin
      pp_count <= pp_count + 9'h001;
    end
  end

  // Status and power-down state brought into the link domain
  always_ff @(posedge serial_clock) begin
    st_s1 <= {deep_power_down, status_lock_bit, 2'h0, protect_range_bits,
              write_enable_latch, busy_flag};
    st_s2 <= st_s1;
  end

  assign out_byte = (opcode == sfpp_pkg::CMD_STATUS_READ) ? st_s2[7:0] : arr_rdata;

  // Output lanes change on falling edges; released while deselected
  always_ff @(negedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      dual_lane_one_out <= 1'h0;
      dual_lane_one_oe_n <= 1'h1;
      dual_lane_zero_out <= 1'h0;
      dual_lane_zero_oe_n <= 1'h1;
      sh <= 8'h00;
    end else if (!fresh && awake && in_data) begin
      dual_lane_one_oe_n <= 1'h0;
      if (dual) begin
        dual_lane_zero_oe_n <= 1'h0;
        if (byte_start) begin
          dual_lane_one_out <= out_byte[7];
          dual_lane_zero_out <= out_byte[6];
          sh <= {out_byte[5:0], 2'h0};
        end else begin
          dual_lane_one_out <= sh[7];
          dual_lane_zero_out <= sh[6];
          sh <= {sh[5:0], 2'h0};
        end
      end else if (byte_start) begin
        dual_lane_one_out <= out_byte[7];
        sh <= {out_byte[6:0], 1'h0};
      end else begin
        dual_lane_one_out <= sh[7];
        sh <= {sh[6:0], 1'h0};
      end
    end
  end

  // ********************************************************
  // Core side: synchronisers and frame-end decode
  // ********************************************************
  typedef enum logic [1:0] {SFPP_IDLE, SFPP_COPY, SFPP_WIPE, SFPP_WAIT} sfpp_state_t;

  sfpp_state_t state;
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic wp_s1;
  logic wp_s2;
  logic frame_end;
  logic whole;
  logic can_cmd;
  logic hw_lock;
  logic is_wipe;
  logic is_chip;
  logic do_set;
  logic do_clear;
  logic st_ok;
  logic er_ok;
  logic pg_ok;
  logic [23:0] limit;
  logic [AW-1:0] er_base;
  logic [AW:0] er_len;
  logic [31:0] start_time;
  logic [AW-1:0] ptr;
  logic [AW:0] left;
  logic [31:0] timer;
  logic stage_v;
  logic stage_wipe;
  logic [AW-1:0] stage_addr;
  logic [7:0] pb_rdata;

  always_ff @(posedge clock) begin
    if (reset) begin
      cs_s1 <= 1'h1;
      cs_s2 <= 1'h1;
      cs_s3 <= 1'h1;
      wp_s1 <= 1'h1;
      wp_s2 <= 1'h1;
    end else begin
      cs_s1 <= chip_select_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      wp_s1 <= write_protect_n;
      wp_s2 <= wp_s1;
    end
  end

  // Frame fields stay still after select rises, so they are read directly
  assign frame_end = cs_s2 && !cs_s3;
  assign whole = (cnt[2:0] == 3'h0) && (cnt >= sfpp_pkg::OPCODE_END);
  assign can_cmd = frame_end && whole && !deep_power_down && !busy_flag;
  assign hw_lock = status_lock_bit && !wp_s2;

  // Protected range decode by density
  always_comb begin
    limit = sfpp_pkg::LIM_NONE;
    if (BIG) begin
      case (protect_range_bits)
        3'h0: limit = sfpp_pkg::LIM_NONE;
        3'h1: limit = sfpp_pkg::LIM_1M_CODE1;
        3'h2: limit = sfpp_pkg::LIM_1M_CODE2;
        3'h3: limit = sfpp_pkg::LIM_1M_CODE3;
        3'h4: limit = sfpp_pkg::LIM_1M_CODE4;
        default: limit = sfpp_pkg::LIM_1M_ALL;
      endcase
    end else begin
      case (protect_range_bits)
        3'h0: limit = sfpp_pkg::LIM_NONE;
        3'h1: limit = sfpp_pkg::LIM_512K_CODE1;
        3'h2: limit = sfpp_pkg::LIM_512K_CODE2;
        3'h3: limit = sfpp_pkg::LIM_512K_CODE3;
        default: limit = sfpp_pkg::LIM_512K_ALL;
      endcase
    end
  end

  // Erase extent and operation time
  always_comb begin
    is_wipe = 1'h1;
    is_chip = 1'h0;
    er_base = addr[AW-1:0] & ~AW'(sfpp_pkg::SECTOR_BYTES - 1);
    er_len = (AW+1)'(sfpp_pkg::SECTOR_BYTES);
    start_time = 32'(SECTOR_CYCLES);
    case (opcode)
      sfpp_pkg::CMD_FOUR_KIB_WIPE: begin
        start_time = 32'(SECTOR_CYCLES);
      end
      sfpp_pkg::CMD_BLOCK32_WIPE: begin
        er_base = addr[AW-1:0] & ~AW'(sfpp_pkg::BLOCK32_BYTES - 1);
        er_len = (AW+1)'(sfpp_pkg::BLOCK32_BYTES);
        start_time = 32'(BLOCK32_CYCLES);
      end
      sfpp_pkg::CMD_BLOCK64_WIPE: begin
        er_base = addr[AW-1:0] & ~AW'(sfpp_pkg::BLOCK64_BYTES - 1);
        er_len = (AW+1)'(sfpp_pkg::BLOCK64_BYTES);
        start_time = 32'(BLOCK64_CYCLES);
      end
      sfpp_pkg::CMD_ARRAY_WIPE_A, sfpp_pkg::CMD_ARRAY_WIPE_B: begin
        is_chip = 1'h1;
        er_base = '0;
        er_len = (AW+1)'(ARRAY_BYTES);
        start_time = BIG ? 32'(ARRAY_1M_CYCLES) : 32'(ARRAY_512K_CYCLES);
      end
      sfpp_pkg::CMD_PAGE_PROGRAM: begin
        is_wipe = 1'h0;
        start_time = 32'(PROGRAM_CYCLES);
      end
      default: begin
        is_wipe = 1'h0;
        start_time = sfpp_pkg::STATUS_WRITE_CYCLES;
      end
    endcase
  end

  assign do_set = can_cmd && (opcode == sfpp_pkg::CMD_SET_WRITE_LATCH);
  assign do_clear = can_cmd && (opcode == sfpp_pkg::CMD_CLEAR_WRITE_LATCH);
  assign st_ok = can_cmd && (opcode == sfpp_pkg::CMD_STATUS_WRITE) && write_enable_latch &&
                 (cnt >= sfpp_pkg::STATUS_DATA_END) && !hw_lock;
  assign er_ok = can_cmd && is_wipe && write_enable_latch && (is_chip || cnt >= sfpp_pkg::ADDR_END) &&
                 (is_chip ? (protect_range_bits == 3'h0) : (24'(er_base) >= limit));
  assign pg_ok = can_cmd && (opcode == sfpp_pkg::CMD_PAGE_PROGRAM) && write_enable_latch &&
                 (cnt >= sfpp_pkg::DUMMY_END) && (pp_count != 9'h000) &&
                 (24'({addr[AW-1:8], 8'h00}) >= limit);

  // ********************************************************
  // Core side: status bits
  // ********************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      write_enable_latch <= sfpp_pkg::RESET_LATCH;
    end else if (do_set) begin
      write_enable_latch <= 1'h1;
    end else if (do_clear || st_ok || er_ok || pg_ok) begin
      write_enable_latch <= 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      protect_range_bits <= sfpp_pkg::RESET_PROTECT;
      status_lock_bit <= sfpp_pkg::RESET_LOCK;
    end else if (st_ok) begin
      protect_range_bits <= sr_data[4:2];
      status_lock_bit <= sr_data[7];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      deep_power_down <= 1'h0;
    end else if (frame_end && deep_power_down && opcode == sfpp_pkg::CMD_WAKE &&
                 cnt >= sfpp_pkg::OPCODE_END) begin
      deep_power_down <= 1'h0;
    end else if (can_cmd && opcode == sfpp_pkg::CMD_POWER_DOWN) begin
      deep_power_down <= 1'h1;
    end
  end

  // ********************************************************
  // Core side: program and erase sequencer
  // ********************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= SFPP_IDLE;
      busy_flag <= 1'h0;
      ptr <= '0;
      left <= '0;
    end else begin
      case (state)
        SFPP_IDLE: begin
          if (pg_ok) begin
            state <= SFPP_COPY;
            busy_flag <= 1'h1;
            ptr <= addr[AW-1:0];
            left <= (AW+1)'(pp_count);
          end else if (er_ok) begin
            state <= SFPP_WIPE;
            busy_flag <= 1'h1;
            ptr <= er_base;
            left <= er_len;
          end else if (st_ok) begin
            state <= SFPP_WAIT;
            busy_flag <= 1'h1;
          end
        end
        SFPP_COPY: begin
          ptr <= {ptr[AW-1:8], ptr[7:0] + 8'h01};
          left <= left - 1'h1;
          if (left == (AW+1)'(1)) begin
            state <= SFPP_WAIT;
          end
        end
        SFPP_WIPE: begin
          ptr <= ptr + 1'h1;
          left <= left - 1'h1;
          if (left == (AW+1)'(1)) begin
            state <= SFPP_WAIT;
          end
        end
        SFPP_WAIT: begin
          if (timer <= 32'h00000001) begin
            state <= SFPP_IDLE;
            busy_flag <= 1'h0;
          end
        end
        default: begin
          state <= SFPP_IDLE;
          busy_flag <= 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      timer <= 32'h00000000;
    end else if (state == SFPP_IDLE) begin
      timer <= start_time;
    end else if (state == SFPP_WAIT) begin
      timer <= timer - 32'h00000001;
    end
  end

  // One write per cycle; buffer read data lines up with the staged address
  always_ff @(posedge clock) begin
    if (reset) begin
      stage_v <= 1'h0;
      stage_wipe <= 1'h0;
      stage_addr <= '0;
    end else begin
      stage_v <= (state == SFPP_COPY) || (state == SFPP_WIPE);
      stage_wipe <= (state == SFPP_WIPE);
      stage_addr <= ptr;
    end
  end

  // ********************************************************
  // Storage
  // ********************************************************
  sfpp_ram #(.DW(8), .AW(8)) page_buffer (
    .wr_clock(serial_clock),
    .wr_en(pb_we),
    .wr_addr(pb_waddr),
    .wr_data(assembled[7:0]),
    .rd_clock(clock),
    .rd_addr(ptr[7:0]),
    .rd_data(pb_rdata)
  );

  sfpp_ram #(.DW(8), .AW(AW)) array (
    .wr_clock(clock),
    .wr_en(stage_v),
    .wr_addr(stage_addr),
    .wr_data(stage_wipe ? sfpp_pkg::ERASED_BYTE : pb_rdata),
    .rd_clock(serial_clock),
    .rd_addr(arr_raddr),
    .rd_data(arr_rdata)
  );

endmodule

// ===== dv/sfpp_chk.sv
`timescale 1ns/100ps
module sfpp_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic dual_lane_zero_oe_n,
  input wire logic dual_lane_one_oe_n,
  input wire logic write_protect_n,
  input wire logic busy_flag,
  input wire logic write_enable_latch,
  input wire logic [2:0] protect_range_bits,
  input wire logic status_lock_bit,
  input wire logic deep_power_down
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ********************************************************
  // Protocol and protection properties
  // ********************************************************
  lane_pair_a: assert property (!dual_lane_zero_oe_n |-> !dual_lane_one_oe_n)
    else $error("lane zero driven without lane one");
  deselect_idle_a: assert property (chip_select_n |-> dual_lane_one_oe_n)
    else $error("output lane driven while deselected");
  latch_set_a: assert property ($rose(write_enable_latch) |->
    !$past(busy_flag) && !$past(deep_power_down))
    else $error("latch set while busy or powered down");
  busy_clears_a: assert property ($rose(busy_flag) |-> !write_enable_latch)
    else $error("latch still set when operation started");
  protect_write_a: assert property ($changed(protect_range_bits) |->
    busy_flag || $past(busy_flag) || $past(write_enable_latch))
    else $error("protect bits changed outside a status write");
  pin_guard_a: assert property ((status_lock_bit && !write_protect_n) [*4] |=>
    $stable(protect_range_bits) && status_lock_bit)
    else $error("guarded status bits changed");
  busy_min_a: assert property ($rose(busy_flag) |-> busy_flag [*8])
    else $error("busy period too short");
  sleep_idle_a: assert property (deep_power_down |-> !busy_flag)
    else $error("busy while powered down");
  cover property ($rose(busy_flag));
  cover property ($rose(deep_power_down));
  cover property (!dual_lane_zero_oe_n);
  cover property ($changed(protect_range_bits));
endmodule
bind sfpp_top sfpp_chk u_chk (.clock(clock), .reset(reset), .chip_select_n(chip_select_n),
  .dual_lane_zero_oe_n(dual_lane_zero_oe_n), .dual_lane_one_oe_n(dual_lane_one_oe_n),
  .write_protect_n(write_protect_n), .busy_flag(busy_flag),
  .write_enable_latch(write_enable_latch), .protect_range_bits(protect_range_bits),
  .status_lock_bit(status_lock_bit), .deep_power_down(deep_power_down));

// ===== dv/sfpp_host.sv
`timescale 1ns/100ps
module sfpp_host (
  output logic serial_clock,
  output logic chip_select_n,
  output logic lane0_drive,
  input wire logic lane0,
  input wire logic lane1
);
  // Select high and clock low from power-up, mode 0 idle
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    lane0_drive = 1'b0;
  end
  // ********************************************************
  // One frame: n bits out, then r read clocks
  // ********************************************************
  task automatic frame(input logic [47:0] tx, input int n, input int r, input bit dual,
                       input bit idle_high, output logic [15:0] rx);
    rx = 16'h0000;
    // Idle level set while deselected: low for mode 0, high for mode 3
    serial_clock = idle_high;
    #3 chip_select_n = 1'b0;
    #3;
    for (int i = n - 1; i >= 0; i--) begin
      serial_clock = 1'b0;
      lane0_drive = tx[i];
      #3 serial_clock = 1'b1;
      #3;
    end
    for (int i = 0; i < r; i++) begin
      // Released lane toggles so stale data cannot match
      serial_clock = 1'b0;
      lane0_drive = ~lane0_drive;
      #3 serial_clock = 1'b1;
      rx = dual ? {rx[13:0], lane1, lane0} : {rx[14:0], lane1};
      #3;
    end
    serial_clock = idle_high;
    #3 chip_select_n = 1'b1;
  endtask
endmodule

// ===== dv/sfpp_top_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module sfpp_top_tb;
  logic clock = 1'b0, reset = 1'b1, write_protect_n = 1'b1;
  logic serial_clock, chip_select_n, lane0_drive, lane0, lane1;
  logic z_out, z_oe_n, o_out, o_oe_n, busy_flag, write_enable_latch;
  logic status_lock_bit, deep_power_down;
  logic [2:0] protect_range_bits;
  logic [15:0] rx;
  int fails = 0, checks = 0;
  assign lane0 = z_oe_n ? lane0_drive : z_out;
  // Released output lane shows the inverse of o_out, which deselect clears to zero
  assign lane1 = o_oe_n ? ~o_out : o_out;
  initial begin
    forever #4 clock = ~clock;
  end
  sfpp_top #(.PROGRAM_CYCLES(20), .SECTOR_CYCLES(20), .BLOCK32_CYCLES(20),
    .BLOCK64_CYCLES(20), .ARRAY_1M_CYCLES(20)) u_dut (
    .clock(clock), .reset(reset), .serial_clock(serial_clock),
    .chip_select_n(chip_select_n), .dual_lane_zero_in(lane0), .dual_lane_zero_out(z_out),
    .dual_lane_zero_oe_n(z_oe_n), .dual_lane_one_out(o_out), .dual_lane_one_oe_n(o_oe_n),
    .write_protect_n(write_protect_n), .busy_flag(busy_flag),
    .write_enable_latch(write_enable_latch), .protect_range_bits(protect_range_bits),
    .status_lock_bit(status_lock_bit), .deep_power_down(deep_power_down));
  sfpp_host u_host (.serial_clock(serial_clock), .chip_select_n(chip_select_n),
    .lane0_drive(lane0_drive), .lane0(lane0), .lane1(lane1));
  // ********************************************************
  // Access tasks
  // ********************************************************
  task automatic run(input logic [47:0] tx, input int n, input int r = 0, input bit d = 0,
                     input bit m3 = 0);
    u_host.frame(tx, n, r, d, m3, rx);
    repeat (10) @(posedge clock);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 5000 && busy_flag !== 1'b0; i++) @(posedge clock);
    if (busy_flag !== 1'b0) begin
      fails++;
      stop_test();
    end
    #1;
  endtask
  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    repeat (3) @(posedge clock);
    #1 reset = 1'b0;
    repeat (2) @(posedge clock);
    `CHK({write_enable_latch, protect_range_bits, status_lock_bit}, 5'h00)
    run(48'h06, 8);
    `CHK(write_enable_latch, 1'b1)
    run(48'h05, 8, 16);
    `CHK(rx[7:0], 8'h02)
    run(48'h04, 8);
    `CHK(write_enable_latch, 1'b0)
    run(48'h00C, 9);
    `CHK(write_enable_latch, 1'b0)
    run(48'h06, 8);
    run(48'h02000100A5, 40);
    `CHK({busy_flag, write_enable_latch}, 2'h2)
    wait_idle();
    run(48'h3B00010000, 40, 4, 1'b1);
    `CHK(rx[7:0], 8'hA5)
    run(48'h0B00010000, 40, 8);
    `CHK(rx[7:0], 8'hA5)
    run(48'h06, 8);
    run(48'h0190, 16);
    `CHK({busy_flag, write_enable_latch}, 2'h2)
    wait_idle();
    `CHK({status_lock_bit, protect_range_bits}, 4'hC)
    run(48'h05, 8, 8, 1'b0, 1'b1);
    `CHK(rx[7:0], 8'h90)
    run(48'h06, 8);
    run(48'h20000000, 32);
    `CHK({busy_flag, write_enable_latch}, 2'h1)
    run(48'h60, 8);
    `CHK({busy_flag, write_enable_latch}, 2'h1)
    run(48'h52008000, 32);
    `CHK({busy_flag, write_enable_latch}, 2'h1)
    run(48'h03000100, 32, 8, 1'b0, 1'b1);
    `CHK(rx[7:0], 8'hA5)
    run(48'h20010000, 32);
    `CHK(busy_flag, 1'b1)
    wait_idle();
    run(48'h0B01000000, 40, 8);
    `CHK(rx[7:0], 8'hFF)
    write_protect_n = 1'b0;
    run(48'h06, 8);
    run(48'h0100, 16);
    `CHK({busy_flag, status_lock_bit, protect_range_bits}, 5'h0C)
    write_protect_n = 1'b1;
    run(48'h06, 8);
    run(48'h0104, 16);
    wait_idle();
    `CHK({status_lock_bit, protect_range_bits}, 4'h1)
    run(48'h06, 8);
    run(48'h2001D000, 32);
    `CHK({busy_flag, write_enable_latch}, 2'h1)
    run(48'h2001E000, 32);
    `CHK({busy_flag, write_enable_latch}, 2'h2)
    wait_idle();
    run(48'hB9, 8);
    `CHK(deep_power_down, 1'b1)
    run(48'h05, 8, 8);
    `CHK(rx[7:0], 8'hFF)
    run(48'h06, 8);
    `CHK(write_enable_latch, 1'b0)
    run(48'hAB, 8);
    `CHK(deep_power_down, 1'b0)
    run(48'h06, 8);
    reset = 1'b1;
    repeat (3) @(posedge clock);
    #1 reset = 1'b0;
    repeat (2) @(posedge clock);
    `CHK({write_enable_latch, protect_range_bits, status_lock_bit}, 5'h00)
    stop_test();
  end
endmodule
